// File: dv/entry_mem_model.sv
`timescale 1ns/100ps
module entry_mem_model (
    // clock
    input wire logic         sys_clk,
    // entry access
    input wire logic         mem_req,
    input wire logic         mem_we,
    input wire logic [31:0]  mem_addr,
    input wire logic [31:0]  mem_wdata,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] addr_q = 32'h0000_0000;
    logic [31:0] data_q = 32'h0000_0000;
    logic        we_q = 1'b0;
    int          lat = 1;
    int          cnt = 0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0000_0000;
    // one access at a time, answered after lat cycles
    always @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata; // released data keeps moving
        if (mem_req) begin
            addr_q = mem_addr;
            data_q = mem_wdata;
            we_q = mem_we;
            cnt = lat;
        end
        if (cnt == 1) begin
            mem_ack <= 1'b1;
            if (we_q) mem[addr_q] = data_q;
            else mem_rdata <= mem.exists(addr_q) ? mem[addr_q] : 32'h0000_0000;
        end
        if (cnt > 0) cnt--;
    end
endmodule

// File: dv/page_entry_decoder_sva.sv
`timescale 1ns/100ps
module page_entry_decoder_sva (
    // clock and bus
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // translation
    input wire logic        xlat_req,
    input wire logic [31:0] xlat_linear,
    input wire logic        task_switch,
    input wire logic        xlat_done,
    input wire logic        xlat_fault,
    input wire logic [1:0]  fault_code,
    input wire logic        tlb_flush,
    // entry memory
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic        walking;
    logic [9:0]  dir_idx;
    logic [31:0] last_rd;
    // walk tracking and last entry read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            walking <= 1'b0;
            dir_idx <= 10'h000;
            last_rd <= 32'h0000_0000;
        end else begin
            if (xlat_req && !walking) begin
                walking <= 1'b1;
                dir_idx <= xlat_linear[31:22];
            end else if (xlat_done) begin
                walking <= 1'b0;
            end
            if (mem_ack) begin
                last_rd <= mem_rdata;
            end
        end
    end
    sequence s_start; xlat_req && !walking; endsequence
    sequence s_wback; mem_req && mem_we; endsequence
    a_dir_read: assert property (
        s_start |-> ##2 mem_req && !mem_we && mem_addr[11:0] == {dir_idx, 2'b00})
        else $error("bad directory read");
    a_walk_ends: assert property (s_start |-> ##[4:80] xlat_done)
        else $error("walk never ends");
    a_done_ack: assert property (xlat_done |-> $past(mem_ack))
        else $error("done without entry");
    a_fault_code: assert property (xlat_fault |-> xlat_done && fault_code != page_entry_pkg::FAULT_NONE)
        else $error("fault without code");
    a_keep_fields: assert property (
        s_wback |-> (mem_wdata & ~32'h0000_0060) == (last_rd & ~32'h0000_0060))
        else $error("entry field altered");
    a_sticky_bits: assert property (
        s_wback |-> mem_wdata[5] && (mem_wdata & last_rd) == last_rd && mem_wdata != last_rd)
        else $error("bad status write");
    a_flush_switch: assert property (task_switch |=> tlb_flush)
        else $error("no flush on switch");
    a_flush_base: assert property (
        reg_write && reg_addr == page_entry_pkg::DIR_BASE_OFFSET |=> tlb_flush)
        else $error("no flush on base load");
    a_read_window: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside slot");
endmodule
bind page_entry_decoder page_entry_decoder_sva u_sva (.sys_clk, .reset_n, .reg_addr, .reg_write, .reg_read,
    .reg_rdata, .xlat_req, .xlat_linear, .task_switch, .xlat_done, .xlat_fault, .fault_code, .tlb_flush,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

// File: dv/tb.sv
`timescale 1ns/100ps
module tb;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        xlat_req = 1'b0;
    logic [31:0] xlat_linear = 32'h0000_0000;
    logic        xlat_is_write = 1'b0;
    logic        task_switch = 1'b0;
    logic        mem_ack, mem_req, mem_we, xlat_done, xlat_fault, tlb_flush, flush_keep_global;
    logic        res_writable, res_user, res_write_through, res_cache_inhibit, res_global, res_large;
    logic [1:0]  fault_code;
    logic [2:0]  res_mem_type_idx;
    logic [31:0] reg_rdata, phys_addr, mem_addr, mem_wdata, mem_rdata;
    int          n_errors = 0;
    int          num_checks = 0;
    page_entry_decoder u_page_entry_decoder (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .xlat_req, .xlat_linear, .xlat_is_write, .task_switch, .xlat_done, .xlat_fault, .fault_code,
        .phys_addr, .res_writable, .res_user, .res_write_through, .res_cache_inhibit, .res_mem_type_idx,
        .res_global, .res_large, .tlb_flush, .flush_keep_global, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_ack, .mem_rdata);
    entry_mem_model u_entry_mem_model (.sys_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    always #5 sys_clk = ~sys_clk;
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic xlat(input logic [31:0] lin, input logic wr);
        @(posedge sys_clk);
        xlat_linear <= lin;
        xlat_is_write <= wr;
        xlat_req <= 1'b1;
        @(posedge sys_clk);
        xlat_req <= 1'b0;
        for (int i = 0; i < 200 && xlat_done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(xlat_done, 1'b1);
        if (xlat_done !== 1'b1) summarize();
    endtask
    task automatic s_small_pages();
        reg_wr(page_entry_pkg::DIR_BASE_OFFSET, 32'h0001_0ABC);
        reg_chk(page_entry_pkg::DIR_BASE_OFFSET, 32'h0001_0000);
        reg_chk(8'h10, 32'h0000_0000);
        u_entry_mem_model.mem[32'h0001_0004] = 32'h0002_0087;
        u_entry_mem_model.mem[32'h0002_0014] = 32'h0003_3303;
        xlat(32'h0040_5123, 1'b1);
        chk(phys_addr, 32'h0003_3123);
        chk(u_entry_mem_model.mem[32'h0001_0004], 32'h0002_00A7);
        chk(u_entry_mem_model.mem[32'h0002_0014], 32'h0003_3363);
        chk({res_writable, res_user, res_global, res_large, res_mem_type_idx}, 7'h40);
    endtask
    task automatic s_large_pages();
        reg_wr(page_entry_pkg::CTRL_OFFSET, 32'h0000_0014);
        reg_chk(page_entry_pkg::CTRL_OFFSET, 32'h0000_0014);
        u_entry_mem_model.lat = 3;
        u_entry_mem_model.mem[32'h0001_0008] = 32'h0C00_11BF;
        xlat(32'h0081_2345, 1'b0);
        chk(phys_addr, 32'h0C01_2345);
        chk({res_write_through, res_cache_inhibit, res_mem_type_idx, res_global, res_large}, 7'h7F);
        reg_wr(page_entry_pkg::CTRL_OFFSET, 32'h0000_0015);
        xlat(32'h0081_2345, 1'b0);
        chk({res_write_through, res_cache_inhibit, res_mem_type_idx, res_global, res_large}, 7'h3B);
        chk(u_entry_mem_model.mem[32'h0001_0008], 32'h0C00_11BF);
        @(posedge sys_clk);
        task_switch <= 1'b1;
        @(posedge sys_clk);
        task_switch <= 1'b0;
        #1 chk({tlb_flush, flush_keep_global}, 2'h3);
    endtask
    task automatic s_faults();
        reg_wr(page_entry_pkg::CTRL_OFFSET, 32'h0000_0000);
        u_entry_mem_model.lat = 2;
        u_entry_mem_model.mem[32'h0001_000C] = 32'hFFFF_FFFE;
        xlat(32'h00C0_0000, 1'b1);
        chk({xlat_fault, fault_code}, 3'h5);
        chk(u_entry_mem_model.mem[32'h0001_000C], 32'hFFFF_FFFE);
        chk(phys_addr, 32'h0C01_2345);
        reg_wr(page_entry_pkg::CTRL_OFFSET, 32'h0000_000C);
        u_entry_mem_model.mem[32'h0001_0010] = 32'h0400_2081;
        xlat(32'h0100_0000, 1'b0);
        chk({xlat_fault, fault_code}, 3'h6);
        reg_chk(page_entry_pkg::FAULT_ADDR_OFFSET, 32'h0100_0000);
        reg_chk(page_entry_pkg::STATUS_OFFSET, 32'h0000_000A);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        s_small_pages();
        s_large_pages();
        s_faults();
        summarize();
    end
endmodule

// File: hdl/entry_decode.sv
`timescale 1ns/100ps

// ****************************************************************
// combinational decode and check of one entry
// ****************************************************************
module entry_decode (
    // entry and context
    input  wire logic [31:0] entry,
    input  wire logic        is_dir,
    input  wire logic        large_page_enable,
    input  wire logic        wide_phys_enable,
    input  wire logic        is_write,
    // decode results
    output logic             present,
    output logic             maps_large,
    output logic             reserved_err,
    output logic             needs_update,
    output logic [31:0]      updated_entry
);

    logic is_leaf;

    // presence gates the large-page select, the reserved check and the update request, not updated_entry
    always_comb begin
        present    = entry[page_entry_pkg::PRESENT_BIT];
        maps_large = present && is_dir && large_page_enable
                     && entry[page_entry_pkg::LARGE_SELECT_BIT];
        is_leaf    = !is_dir || maps_large;
    end

    // reserved bits only checked with both enables set
    always_comb begin
        reserved_err = 1'b0;
        if (present && large_page_enable && wide_phys_enable) begin
            if (maps_large) begin
                reserved_err = |entry[page_entry_pkg::LARGE_RSVD_MSB:page_entry_pkg::LARGE_RSVD_LSB];
            end else if (is_dir) begin
                reserved_err = entry[page_entry_pkg::DIRTY_BIT];
            end
        end
    end

    // accessed set, dirty set only on leaf writes, nothing else touched
    always_comb begin
        updated_entry = entry;
        updated_entry[page_entry_pkg::ACCESSED_BIT] = 1'b1;
        if (is_leaf && is_write) begin
            updated_entry[page_entry_pkg::DIRTY_BIT] = 1'b1;
        end
        needs_update = present && !reserved_err && (updated_entry != entry);
    end

endmodule

// File: hdl/page_entry_decoder.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module page_entry_decoder (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // translation request
    input  wire logic        xlat_req,
    input  wire logic [31:0] xlat_linear,
    input  wire logic        xlat_is_write,
    input  wire logic        task_switch,
    // translation result
    output logic             xlat_done,
    output logic             xlat_fault,
    output logic      [1:0]  fault_code,
    output logic      [31:0] phys_addr,
    output logic             res_writable,
    output logic             res_user,
    output logic             res_write_through,
    output logic             res_cache_inhibit,
    output logic      [2:0]  res_mem_type_idx,
    output logic             res_global,
    output logic             res_large,
    // translation cache flush
    output logic             tlb_flush,
    output logic             flush_keep_global,
    // entry memory
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // byte address of entry idx in a 4-KByte table
    function automatic logic [31:0] entry_addr(input logic [19:0] base, input logic [9:0] idx);
        entry_addr = {base, idx, 2'b00};
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    // walk states
    typedef enum logic [6:0] {
        ST_IDLE     = 7'b000_0001,
        ST_DIR_RD   = 7'b000_0010,
        ST_DIR_WAIT = 7'b000_0100,
        ST_TBL_RD   = 7'b000_1000,
        ST_TBL_WAIT = 7'b001_0000,
        ST_UPD_WR   = 7'b010_0000,
        ST_UPD_WAIT = 7'b100_0000
    } walk_state_t;

    walk_state_t  state;
    logic [4:0]   ctrl;
    logic [31:0]  dir_base;
    logic [31:0]  lin;
    logic         is_write;
    logic [31:0]  dir_entry;
    logic [31:0]  tbl_entry;
    logic [31:0]  fault_addr;
    logic         last_fault;
    logic [1:0]   last_code;
    logic         upd_tbl_pending;
    logic [31:0]  upd_tbl_data;
    logic [31:0]  upd_tbl_addr;

    logic         cache_off;
    logic         large_en;
    logic         wide_en;
    logic         keep_en;
    logic         write_protect;

    // decode outputs
    logic         cur_is_dir;
    logic         dec_present;
    logic         dec_large;
    logic         dec_rsvd;
    logic         dec_upd;
    logic [31:0]  dec_entry;

    always_comb begin
        cache_off     = ctrl[page_entry_pkg::CTRL_CACHE_OFF_BIT];
        write_protect = ctrl[page_entry_pkg::CTRL_WP_BIT];
        large_en      = ctrl[page_entry_pkg::CTRL_LARGE_EN_BIT];
        wide_en       = ctrl[page_entry_pkg::CTRL_WIDE_EN_BIT];
        keep_en       = ctrl[page_entry_pkg::CTRL_GLOBAL_KEEP_BIT];
        cur_is_dir    = (state == ST_DIR_WAIT);
    end

    entry_decode u_decode (
        .entry             (mem_rdata),
        .is_dir            (cur_is_dir),
        .large_page_enable (large_en),
        .wide_phys_enable  (wide_en),
        .is_write          (is_write),
        .present           (dec_present),
        .maps_large        (dec_large),
        .reserved_err      (dec_rsvd),
        .needs_update      (dec_upd),
        .updated_entry     (dec_entry)
    );

    // ****************************************************************
    // register file
    // ****************************************************************

    // control and directory base writes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl     <= page_entry_pkg::CTRL_RESET;
            dir_base <= page_entry_pkg::DIR_BASE_RESET;
        end else if (reg_write) begin
            if (reg_addr == page_entry_pkg::CTRL_OFFSET) begin
                ctrl <= reg_wdata[page_entry_pkg::CTRL_BITS-1:0];
            end
            if (reg_addr == page_entry_pkg::DIR_BASE_OFFSET) begin
                dir_base <= {reg_wdata[31:12], 12'h000};
            end
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                page_entry_pkg::CTRL_OFFSET:       reg_rdata <= {27'h000_0000, ctrl};
                page_entry_pkg::DIR_BASE_OFFSET:   reg_rdata <= dir_base;
                page_entry_pkg::STATUS_OFFSET:     reg_rdata <= {28'h000_0000, last_code, last_fault,
                                                                 (state != ST_IDLE)};
                page_entry_pkg::FAULT_ADDR_OFFSET: reg_rdata <= fault_addr;
                default:                           reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // flush on base reload or task switch
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tlb_flush         <= 1'b0;
            flush_keep_global <= 1'b0;
        end else begin
            tlb_flush <= task_switch
                         || (reg_write && reg_addr == page_entry_pkg::DIR_BASE_OFFSET);
            flush_keep_global <= keep_en;
        end
    end

    // ****************************************************************
    // walk state machine
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state           <= ST_IDLE;
            lin             <= 32'h0000_0000;
            is_write        <= 1'b0;
            dir_entry       <= 32'h0000_0000;
            tbl_entry       <= 32'h0000_0000;
            upd_tbl_pending <= 1'b0;
            upd_tbl_data    <= 32'h0000_0000;
            upd_tbl_addr    <= 32'h0000_0000;
            mem_req         <= 1'b0;
            mem_we          <= 1'b0;
            mem_addr        <= 32'h0000_0000;
            mem_wdata       <= 32'h0000_0000;
        end else begin
            mem_req <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (xlat_req) begin
                        lin      <= xlat_linear;
                        is_write <= xlat_is_write;
                        state    <= ST_DIR_RD;
                    end
                end
                ST_DIR_RD: begin
                    mem_req  <= 1'b1;
                    mem_we   <= 1'b0;
                    mem_addr <= entry_addr(dir_base[31:12], lin[31:22]);
                    state    <= ST_DIR_WAIT;
                end
                ST_DIR_WAIT: begin
                    if (mem_ack) begin
                        dir_entry <= mem_rdata;
                        if (!dec_present || dec_rsvd) begin
                            state <= ST_IDLE;
                        end else if (dec_upd) begin
                            mem_req   <= 1'b1;
                            mem_we    <= 1'b1;
                            mem_wdata <= dec_entry;
                            state     <= ST_UPD_WAIT;
                        end else if (dec_large) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_TBL_RD;
                        end
                    end
                end
                ST_TBL_RD: begin
                    mem_req  <= 1'b1;
                    mem_we   <= 1'b0;
                    mem_addr <= entry_addr(dir_entry[31:12], lin[21:12]);
                    state    <= ST_TBL_WAIT;
                end
                ST_TBL_WAIT: begin
                    if (mem_ack) begin
                        tbl_entry <= mem_rdata;
                        if (!dec_present || dec_rsvd || !dec_upd) begin
                            state <= ST_IDLE;
                        end else begin
                            upd_tbl_pending <= 1'b1;
                            upd_tbl_data    <= dec_entry;
                            upd_tbl_addr    <= mem_addr;
                            state           <= ST_UPD_WR;
                        end
                    end
                end
                ST_UPD_WR: begin
                    mem_req         <= 1'b1;
                    mem_we          <= 1'b1;
                    mem_addr        <= upd_tbl_addr;
                    mem_wdata       <= upd_tbl_data;
                    state           <= ST_UPD_WAIT;
                end
                ST_UPD_WAIT: begin
                    if (mem_ack) begin
                        mem_we          <= 1'b0;
                        upd_tbl_pending <= 1'b0;
                        if ((dir_entry[page_entry_pkg::LARGE_SELECT_BIT] && large_en) || upd_tbl_pending) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_TBL_RD;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // results
    // ****************************************************************
    logic finish_fault;
    logic finish_large;
    logic finish_tbl;
    logic finish_upd;

    // completion conditions of the walk
    always_comb begin
        finish_fault = mem_ack && (state == ST_DIR_WAIT || state == ST_TBL_WAIT)
                       && (!dec_present || dec_rsvd);
        finish_large = mem_ack && state == ST_DIR_WAIT && dec_present && !dec_rsvd
                       && dec_large && !dec_upd;
        finish_tbl   = mem_ack && state == ST_TBL_WAIT && dec_present && !dec_rsvd && !dec_upd;
        finish_upd   = mem_ack && state == ST_UPD_WAIT
                       && ((dir_entry[page_entry_pkg::LARGE_SELECT_BIT] && large_en)
                           || upd_tbl_pending);
    end

    logic [31:0] leaf;
    logic        leaf_large;
    logic [31:0] pde_v;

    // pick the leaf entry as seen this cycle
    always_comb begin
        pde_v      = (state == ST_DIR_WAIT) ? mem_rdata : dir_entry;
        leaf_large = large_en && pde_v[page_entry_pkg::LARGE_SELECT_BIT];
        if (state == ST_TBL_WAIT) begin
            leaf = mem_rdata;
        end else if (leaf_large) begin
            leaf = pde_v;
        end else begin
            leaf = tbl_entry;
        end
    end

    // result registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            xlat_done         <= 1'b0;
            xlat_fault        <= 1'b0;
            fault_code        <= page_entry_pkg::FAULT_NONE;
            phys_addr         <= 32'h0000_0000;
            res_writable      <= 1'b0;
            res_user          <= 1'b0;
            res_write_through <= 1'b0;
            res_cache_inhibit <= 1'b0;
            res_mem_type_idx  <= 3'h0;
            res_global        <= 1'b0;
            res_large         <= 1'b0;
        end else begin
            xlat_done  <= finish_fault || finish_large || finish_tbl || finish_upd;
            xlat_fault <= finish_fault;
            if (finish_fault) begin
                fault_code <= dec_present ? page_entry_pkg::FAULT_RESERVED
                                          : page_entry_pkg::FAULT_NOT_PRESENT;
            end else if (finish_large || finish_tbl || finish_upd) begin
                fault_code <= page_entry_pkg::FAULT_NONE;
                res_large  <= leaf_large;
                if (leaf_large) begin
                    phys_addr <= {leaf[31:page_entry_pkg::LARGE_BASE_LSB], lin[21:0]};
                end else begin
                    phys_addr <= {leaf[31:page_entry_pkg::BASE_LSB], lin[11:0]};
                end
                // rights combined over the directory and the leaf
                res_writable <= pde_v[page_entry_pkg::WRITABLE_BIT] && leaf[page_entry_pkg::WRITABLE_BIT]
                                && !(write_protect && !leaf[page_entry_pkg::USER_BIT]
                                     && !leaf[page_entry_pkg::WRITABLE_BIT]);
                res_user     <= pde_v[page_entry_pkg::USER_BIT] && leaf[page_entry_pkg::USER_BIT];
                res_write_through <= !cache_off && leaf[page_entry_pkg::WRITE_THROUGH_BIT];
                res_cache_inhibit <= cache_off || leaf[page_entry_pkg::CACHE_INHIBIT_BIT];
                res_mem_type_idx  <= {leaf_large ? leaf[page_entry_pkg::LARGE_TYPE_HI_BIT]
                                                 : leaf[page_entry_pkg::TBL_TYPE_HI_BIT],
                                      cache_off || leaf[page_entry_pkg::CACHE_INHIBIT_BIT],
                                      !cache_off && leaf[page_entry_pkg::WRITE_THROUGH_BIT]};
                res_global <= keep_en && leaf[page_entry_pkg::GLOBAL_BIT];
            end
        end
    end

    // fault capture for software
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_addr <= 32'h0000_0000;
            last_fault <= 1'b0;
            last_code  <= page_entry_pkg::FAULT_NONE;
        end else if (finish_fault) begin
            fault_addr <= lin;
            last_fault <= 1'b1;
            last_code  <= dec_present ? page_entry_pkg::FAULT_RESERVED : page_entry_pkg::FAULT_NOT_PRESENT;
        end else if (finish_large || finish_tbl || finish_upd) begin
            last_fault <= 1'b0;
            last_code  <= page_entry_pkg::FAULT_NONE;
        end
    end

endmodule

// File: hdl/page_entry_pkg.sv
package page_entry_pkg;

    // ****************************************************************
    // entry field positions
    // ****************************************************************
    localparam int PRESENT_BIT       = 0;
    localparam int WRITABLE_BIT      = 1;
    localparam int USER_BIT          = 2;
    localparam int WRITE_THROUGH_BIT = 3;
    localparam int CACHE_INHIBIT_BIT = 4;
    localparam int ACCESSED_BIT      = 5;
    localparam int DIRTY_BIT         = 6;
    localparam int LARGE_SELECT_BIT  = 7;
    localparam int TBL_TYPE_HI_BIT   = 7;
    localparam int GLOBAL_BIT        = 8;
    localparam int LARGE_TYPE_HI_BIT = 12;
    localparam int BASE_LSB          = 12;
    localparam int LARGE_BASE_LSB    = 22;
    localparam int LARGE_RSVD_LSB    = 13;
    localparam int LARGE_RSVD_MSB    = 21;
    localparam int BASE_BITS         = 20;
    localparam int LARGE_BASE_BITS   = 10;
    localparam int INDEX_BITS        = 10;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] CTRL_OFFSET       = 8'h00;
    localparam logic [7:0] DIR_BASE_OFFSET   = 8'h04;
    localparam logic [7:0] STATUS_OFFSET     = 8'h08;
    localparam logic [7:0] FAULT_ADDR_OFFSET = 8'h0C;

    // control register fields
    localparam int CTRL_CACHE_OFF_BIT   = 0;
    localparam int CTRL_WP_BIT          = 1;
    localparam int CTRL_LARGE_EN_BIT    = 2;
    localparam int CTRL_WIDE_EN_BIT     = 3;
    localparam int CTRL_GLOBAL_KEEP_BIT = 4;
    localparam int CTRL_BITS            = 5;

    // reset values
    localparam logic [4:0]  CTRL_RESET     = 5'h00;
    localparam logic [31:0] DIR_BASE_RESET = 32'h0000_0000;

    // fault codes
    localparam logic [1:0] FAULT_NONE        = 2'h0;
    localparam logic [1:0] FAULT_NOT_PRESENT = 2'h1;
    localparam logic [1:0] FAULT_RESERVED    = 2'h2;

endpackage
